// >>> rtl/leak_alarm_pkg.sv
// Purpose: Shared constants for the leak alarm output and configuration block.
// Assumes: 10 MHz system clock; classic Wishbone with 32-bit data.
// Notes:   Offsets are byte addresses, one aligned word per register.
package leak_alarm_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] SERIAL_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS    = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h10;
  localparam logic [7:0] AREA_CMD_OFS  = 8'h14;
  localparam logic [7:0] AREA_IDX_OFS  = 8'h18;
  localparam logic [7:0] AREA_DIST_OFS = 8'h1C;
  localparam logic [7:0] AREA_NAME_OFS = 8'h20;
  // CTRL fields
  localparam int CTRL_SENSE_BIT  = 0;
  localparam int CTRL_POLICY_LSB = 1;
  localparam int CTRL_MODBUS_BIT = 3;
  // SERIAL fields
  localparam int SER_BAUD_LSB    = 0;
  localparam int SER_DATA8_BIT   = 2;
  localparam int SER_STOP2_BIT   = 3;
  localparam int SER_PARITY_LSB  = 4;
  localparam int SER_STATION_LSB = 8;
  localparam int SER_DELAY_LSB   = 16;
  // AREA_CMD fields
  localparam int CMD_DELETE_BIT  = 0;
  localparam int CMD_CONFIRM_BIT = 1;
  localparam int CMD_CANCEL_BIT  = 2;
  // Interrupt event bits
  localparam int EV_ONSET = 0;
  localparam int EV_MRST  = 1;
  localparam int EV_DEL   = 2;
  localparam int EV_REPLY = 3;
  localparam int EV_W     = 4;
  // Values after reset and limits
  localparam logic [31:0] CTRL_RST   = 32'h0000_0004;
  localparam logic [31:0] SERIAL_RST = 32'h0000_0105;
  localparam logic [9:0]  AREA_DEF_END  = 10'h2BB;
  localparam logic [31:0] AREA_DEF_NAME = 32'h4145_5241;
  localparam logic [4:0]  AREA_MAX   = 5'h14;
  localparam logic [6:0]  DELAY_MAX  = 7'h63;
  // Encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  typedef enum logic [1:0] {POL_AUTO, POL_MANUAL_ONE, POL_LATCHED} policy_e;
  // Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int DEBOUNCE_MS    = 10;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int REPLY_UNIT_MS  = 1;
  localparam int REPLY_UNIT_CYC = REPLY_UNIT_MS * (CLK_HZ / 1000);
endpackage

// >>> rtl/leak_alarm_output_config.sv
// Purpose: Area list upkeep, relay sense, alarm reset policy and serial settings.
// Assumes: Inputs synchronous to sys_clk_i except the external reset contact.
// Notes:   Wishbone classic slave; one wait state, ack one cycle after the strobe.
`timescale 1ns/1ps

// Functional notes
// - Deleting inner area shifts later areas down
// - Deleting sole area restores default range, name
// - Delete needs confirm; cancel leaves list unchanged
// - Relay drive inverted per contact sense
// - Auto policy: self clear, ignore resets
// - Manual one: self clear, alarm resettable
// - Latched policy: hold until manual reset
// - Reset from key chord or external contact
// - Manual reset clears only the alarm and relay outputs while a condition is present
// - Serial rate one of four, host matches
// - Modbus stop bits follow parity setting
// - Wait reply delay before answering host
module leak_alarm_output_config
  import leak_alarm_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int REPLY_UNIT_CYCLES = REPLY_UNIT_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        leak_i,
  input  wire logic        disc_i,
  input  wire logic        cancel_key_i,
  input  wire logic        second_function_key_i,
  input  wire logic        ext_reset_n_i,
  input  wire logic        reply_req_i,
  output logic             reply_go_o,
  output logic             relay_o,
  output logic             alarm_o,
  output logic             leak_out_o,
  output logic             disc_out_o,
  output logic             backlight_o,
  output logic       [1:0] baud_sel_o,
  output logic             data8_o,
  output logic             stop_two_o,
  output logic       [1:0] parity_o,
  output logic             irq_o
);
  typedef enum logic {DEL_IDLE, DEL_CONFIRM} del_state_e;

  logic [31:0] ctrl_ff, serial_ff;
  logic [EV_W-1:0] irq_stat_ff, irq_mask_ff;
  logic [4:0]  area_idx_ff, area_cnt_ff, del_idx_ff;
  logic [9:0]  area_end_ff  [20];
  logic [31:0] area_name_ff [20];
  del_state_e  del_state_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        ext_meta_ff, ext_sync_ff, ext_stable_ff, ext_stable_d_ff;
  logic [16:0] deb_cnt_ff;
  logic        chord_d_ff, cond_d_ff;
  logic        silenced_ff, leak_lat_ff, disc_lat_ff;
  logic [6:0]  units_ff;
  logic [13:0] unit_cnt_ff;
  logic        waiting_ff;

  // Bus decode, a request is taken in the cycle before ack is raised
  wire        req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wr       = req & wb_we_i;
  wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wr_ctrl  = wr & (wb_adr_i == CTRL_OFS);
  wire        wr_ser   = wr & (wb_adr_i == SERIAL_OFS);
  wire        wr_istat = wr & (wb_adr_i == IRQ_STAT_OFS);
  wire        wr_imask = wr & (wb_adr_i == IRQ_MASK_OFS);
  wire        wr_cmd   = wr & (wb_adr_i == AREA_CMD_OFS) & wb_sel_i[0];
  wire        wr_idx   = wr & (wb_adr_i == AREA_IDX_OFS) & wb_sel_i[0];
  wire        wr_dist  = wr & (wb_adr_i == AREA_DIST_OFS);
  wire        wr_name  = wr & (wb_adr_i == AREA_NAME_OFS);

  // Configuration fields
  wire        sense_nc  = ctrl_ff[CTRL_SENSE_BIT];
  wire [1:0]  policy    = ctrl_ff[CTRL_POLICY_LSB +: 2];
  wire        modbus    = ctrl_ff[CTRL_MODBUS_BIT];
  wire [1:0]  parity    = serial_ff[SER_PARITY_LSB +: 2];
  wire [6:0]  delay_set = serial_ff[SER_DELAY_LSB +: 7];
  wire        stop_two  = modbus ? (parity == PAR_NONE) : serial_ff[SER_STOP2_BIT];
  wire        data8     = modbus | serial_ff[SER_DATA8_BIT];

  // Condition and manual reset sources
  wire cond       = leak_i | disc_i;
  wire any_out    = leak_lat_ff | disc_lat_ff | cond;
  wire chord      = cancel_key_i & second_function_key_i & any_out;
  wire ext_rise   = ext_stable_ff & ~ext_stable_d_ff;
  wire mrst_req   = (chord & ~chord_d_ff) | ext_rise;
  wire mrst_ok    = mrst_req & (policy != POL_AUTO);
  wire onset      = cond & ~cond_d_ff;

  // Area list, reply and event decode
  wire del_start  = wr_cmd & wb_dat_i[CMD_DELETE_BIT] & (del_state_ff == DEL_IDLE)
                    & (area_idx_ff < area_cnt_ff);
  wire del_do     = wr_cmd & wb_dat_i[CMD_CONFIRM_BIT] & (del_state_ff == DEL_CONFIRM);
  wire del_cancel = wr_cmd & wb_dat_i[CMD_CANCEL_BIT] & (del_state_ff == DEL_CONFIRM);
  wire del_sole   = del_do & (area_cnt_ff == 5'h01);
  wire appending  = wr_dist & (area_idx_ff == area_cnt_ff) & (area_cnt_ff < AREA_MAX)
                    & (del_state_ff == DEL_IDLE);
  wire edit_ok    = (area_idx_ff < area_cnt_ff) & (del_state_ff == DEL_IDLE);
  wire reply_done = waiting_ff & (units_ff == 7'h00);
  wire [EV_W-1:0] ev = {reply_done, del_do, mrst_ok, onset};

  // Output next values
  // Latched outputs held until reset with condition gone
  wire nxt_leak_lat = leak_i | (leak_lat_ff & ~(mrst_ok & ~cond));
  wire nxt_disc_lat = disc_i | (disc_lat_ff & ~(mrst_ok & ~cond));
  wire nxt_silenced = ~onset & any_out & (silenced_ff | mrst_ok);
  wire held         = (policy == POL_LATCHED);
  wire nxt_leak     = held ? nxt_leak_lat : leak_i;
  wire nxt_disc     = held ? nxt_disc_lat : disc_i;
  wire nxt_alarm    = (nxt_leak | nxt_disc) & ~((policy != POL_AUTO) & nxt_silenced);

  // Read mux
  // Count sits at bits 11:7; the zero fill keeps the word at 32 bits
  wire [31:0] status_w = {20'h0, area_cnt_ff, del_state_ff == DEL_CONFIRM, stop_two,
                          backlight_o, disc_out_o, leak_out_o, alarm_o, ext_stable_ff};
  wire [31:0] rsel =
    (wb_adr_i == CTRL_OFS)      ? ctrl_ff :
    (wb_adr_i == SERIAL_OFS)    ? serial_ff :
    (wb_adr_i == STATUS_OFS)    ? status_w :
    (wb_adr_i == IRQ_STAT_OFS)  ? {28'h0, irq_stat_ff} :
    (wb_adr_i == IRQ_MASK_OFS)  ? {28'h0, irq_mask_ff} :
    (wb_adr_i == AREA_CMD_OFS)  ? {27'h0, del_idx_ff} :
    (wb_adr_i == AREA_IDX_OFS)  ? {27'h0, area_idx_ff} :
    (wb_adr_i == AREA_DIST_OFS) ?
      {22'h0, (area_idx_ff < AREA_MAX) ? area_end_ff[area_idx_ff] : 10'h0} :
    (wb_adr_i == AREA_NAME_OFS) ? ((area_idx_ff < AREA_MAX) ? area_name_ff[area_idx_ff] : 32'h0) :
    32'h0;

  // Bus answer; unmapped offsets ack with zero data
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff   <= req;
      rdata_ff <= req ? rsel : 32'h0;
    end
  end

  // Configuration registers; reply delay clamps at 99
  // Rate select kept as a two-bit code
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_ff   <= CTRL_RST;
      serial_ff <= SERIAL_RST;
    end else begin
      if (wr_ctrl)
        ctrl_ff <= (ctrl_ff & ~wmask) | (wb_dat_i & wmask & 32'h0000_000F);
      if (wr_ser)
        serial_ff <= (serial_ff & ~wmask) | (wb_dat_i & wmask & 32'h007F_1F3F);
      else if (delay_set > DELAY_MAX)
        serial_ff[SER_DELAY_LSB +: 7] <= DELAY_MAX;
    end
  end

  // Sticky events, set wins over write-one-to-clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_o       <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_istat & wb_sel_i[0] ? wb_dat_i[EV_W-1:0] : '0)) | ev;
      if (wr_imask && wb_sel_i[0])
        irq_mask_ff <= wb_dat_i[EV_W-1:0];
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Delete waits for confirm or cancel
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      del_state_ff <= DEL_IDLE;
      del_idx_ff   <= 5'h0;
      area_idx_ff  <= 5'h0;
      area_cnt_ff  <= 5'h01;
    end else begin
      unique case (del_state_ff)
        DEL_IDLE: begin
          if (del_start) begin
            del_state_ff <= DEL_CONFIRM;
            del_idx_ff   <= area_idx_ff;
          end
        end
        DEL_CONFIRM: begin
          if (del_do || del_cancel)
            del_state_ff <= DEL_IDLE;
        end
      endcase
      if (del_do) begin
        area_idx_ff <= 5'h0; // Back to the first area view
        if (!del_sole)
          area_cnt_ff <= area_cnt_ff - 5'h01;
      end else if (wr_idx && del_state_ff == DEL_IDLE) begin
        area_idx_ff <= wb_dat_i[4:0];
      end else if (appending) begin
        area_cnt_ff <= area_cnt_ff + 5'h01;
      end
    end
  end

  // Area entries: one shift slot per entry
  for (genvar i = 0; i < 20; i++) begin : g_area
    localparam logic [4:0] IDX = 5'(i);
    wire shift_in = del_do & (IDX >= del_idx_ff) & (IDX < area_cnt_ff - 5'h01);
    wire restore  = del_sole & (i == 0);
    wire upd      = (IDX == area_idx_ff) & (edit_ok | appending);
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        area_end_ff[i]  <= AREA_DEF_END;
        area_name_ff[i] <= AREA_DEF_NAME;
      end else if (restore) begin
        area_end_ff[i]  <= AREA_DEF_END;
        area_name_ff[i] <= AREA_DEF_NAME;
      // Later entry moves down with name
      end else if (shift_in) begin
        if (i < 19) begin
          area_end_ff[i]  <= area_end_ff[(i < 19) ? i + 1 : i];
          area_name_ff[i] <= area_name_ff[(i < 19) ? i + 1 : i];
        end
      end else if (upd && wr_dist) begin
        area_end_ff[i] <= wb_dat_i[9:0];
      end else if (upd && wr_name) begin
        area_name_ff[i] <= (area_name_ff[i] & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end

  // Contact synchronised then debounced; shorted means low
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_meta_ff     <= 1'b0;
      ext_sync_ff     <= 1'b0;
      ext_stable_ff   <= 1'b0;
      ext_stable_d_ff <= 1'b0;
      deb_cnt_ff      <= 17'h0;
    end else begin
      ext_meta_ff     <= ~ext_reset_n_i;
      ext_sync_ff     <= ext_meta_ff;
      ext_stable_d_ff <= ext_stable_ff;
      if (ext_sync_ff == ext_stable_ff)
        deb_cnt_ff <= 17'h0;
      else if (deb_cnt_ff >= 17'(DEBOUNCE_CYCLES - 1)) begin
        deb_cnt_ff    <= 17'h0;
        ext_stable_ff <= ext_sync_ff;
      end else
        deb_cnt_ff <= deb_cnt_ff + 17'h1;
    end
  end

  // Alarm state and registered outputs
  // Contact drive inverted for normally closed
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chord_d_ff  <= 1'b0;
      cond_d_ff   <= 1'b0;
      silenced_ff <= 1'b0;
      leak_lat_ff <= 1'b0;
      disc_lat_ff <= 1'b0;
      alarm_o     <= 1'b0;
      relay_o     <= 1'b0;
      leak_out_o  <= 1'b0;
      disc_out_o  <= 1'b0;
      backlight_o <= 1'b0;
    end else begin
      chord_d_ff  <= chord;
      cond_d_ff   <= cond;
      silenced_ff <= nxt_silenced;
      leak_lat_ff <= held & nxt_leak_lat;
      disc_lat_ff <= held & nxt_disc_lat;
      alarm_o     <= nxt_alarm;
      relay_o     <= nxt_alarm ^ sense_nc;
      leak_out_o  <= nxt_leak;
      disc_out_o  <= nxt_disc;
      backlight_o <= nxt_leak | nxt_disc;
    end
  end

  // Reply held for delay times the unit
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      waiting_ff  <= 1'b0;
      units_ff    <= 7'h0;
      unit_cnt_ff <= 14'h0;
      reply_go_o  <= 1'b0;
    end else begin
      reply_go_o <= reply_done;
      if (reply_req_i && !waiting_ff) begin
        waiting_ff  <= 1'b1;
        units_ff    <= delay_set;
        unit_cnt_ff <= 14'h0;
      end else if (reply_done) begin
        waiting_ff <= 1'b0;
      end else if (waiting_ff) begin
        if (unit_cnt_ff >= 14'(REPLY_UNIT_CYCLES - 1)) begin
          unit_cnt_ff <= 14'h0;
          units_ff    <= units_ff - 7'h1;
        end else
          unit_cnt_ff <= unit_cnt_ff + 14'h1;
      end
    end
  end

  // Serial settings to the line logic
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      baud_sel_o <= 2'h0;
      data8_o    <= 1'b0;
      stop_two_o <= 1'b0;
      parity_o   <= 2'h0;
    end else begin
      baud_sel_o <= serial_ff[SER_BAUD_LSB +: 2];
      data8_o    <= data8;
      stop_two_o <= stop_two;
      parity_o   <= parity;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_sole_restore: assert property (del_sole |=> area_cnt_ff == 5'h01 && area_end_ff[0] == AREA_DEF_END)
    else $error("sole area not restored");
  a_shift_count: assert property (del_do && !del_sole |=> area_cnt_ff == $past(area_cnt_ff) - 5'h01)
    else $error("area count not reduced");
  a_cancel_keeps: assert property (del_cancel |=> $stable(area_cnt_ff) && del_state_ff == DEL_IDLE)
    else $error("cancel changed list");
  a_relay_sense: assert property (relay_o == (alarm_o ^ sense_nc) || $changed(sense_nc))
    else $error("relay sense wrong");
  a_auto_follow: assert property (policy == POL_AUTO && $stable(policy) |-> alarm_o == $past(cond))
    else $error("auto alarm not following");
  a_manual_clear: assert property (policy == POL_MANUAL_ONE && mrst_ok && cond && !onset |=> !alarm_o)
    else $error("manual reset ignored");
  a_latched_hold: assert property (held && leak_lat_ff && !cond && !mrst_ok ##1 held |-> leak_out_o)
    else $error("latched output dropped");
  a_leak_kept: assert property (mrst_ok && leak_i && $stable(policy) |=> leak_out_o && backlight_o)
    else $error("manual reset cleared leak output");
  a_modbus_stop: assert property (modbus |=> stop_two_o == ($past(parity) == PAR_NONE))
    else $error("modbus stop bits wrong");
  a_reply_zero: assert property (reply_req_i && !waiting_ff && delay_set == 7'h00 |-> ##2 reply_go_o)
    else $error("zero delay reply late");
  a_ext_reset: assert property (ext_rise && policy == POL_LATCHED |-> mrst_ok)
    else $error("external reset not taken");
  c_delete_mid: cover property (del_do && del_idx_ff == 5'h01 && area_cnt_ff == 5'h03);
  c_chord_reset: cover property (chord && !chord_d_ff && policy == POL_MANUAL_ONE);
  c_latched_clear: cover property (held && mrst_ok && !cond);
  c_reply_delay: cover property (reply_done && delay_set == 7'h02);
endmodule

// >>> bench/host_contact_model.sv
// Purpose: Host controller and external reset contact beside the alarm block.
// Assumes: A shorted contact pulls the line low; the host asks one reply at a time.
// Notes:   The contact bounces for a few cycles before it settles, like a real switch.
`timescale 1ns/1ps
module host_contact_model #(
  parameter logic [1:0] HOST_BAUD_CODE = 2'h1
) (
  input  wire logic sys_clk_i,
  output logic      ext_reset_n_o,
  output logic      reply_req_o
);
  // Contact open and host quiet at power up
  initial begin
    ext_reset_n_o = 1'h1;
    reply_req_o   = 1'h0;
  end

  task automatic set_contact(input logic shorted);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      ext_reset_n_o <= (i % 2 == 1) ? ~shorted : shorted;
    end
  endtask

  // host drives one request for a single cycle; HOST_BAUD_CODE is not used here
  task automatic send_request();
    @(posedge sys_clk_i);
    reply_req_o <= 1'h1;
    @(posedge sys_clk_i);
    reply_req_o <= 1'h0;
  endtask
endmodule

// >>> bench/tb_leak_alarm_output_config.sv
// Purpose: Self-checking bench for the leak alarm output and configuration block.
// Assumes: Short debounce and reply unit counts keep the run brief.
// Notes:   Outputs are read right after a rising edge, before that edge's updates land.
`timescale 1ns/1ps
module tb_leak_alarm_output_config;
  import leak_alarm_pkg::*;
  localparam int UNIT = 3;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] ser;
    logic        lk;
    logic        rly;
    logic [1:0]  bd;
    logic        st2;
    logic        d8;
  } row_s;
  logic        sys_clk_i, reset_n_i, cyc, stb, we, ack, leak, disc, k_can, k_sec;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        go, relay, alarm, lk_o, dc_o, blt, d8, st2, irq, ext_n, req;
  logic [1:0]  baud, par;
  int          bad_count, total_checks, n;
  // Auto policy rows: contact sense, rate, stop bits
  row_s rows [6] = '{'{32'h0, 32'h0, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0},
                     '{32'h1, 32'h9, 1'h1, 1'h0, 2'h1, 1'h1, 1'h0},
                     '{32'h1, 32'h2, 1'h0, 1'h1, 2'h2, 1'h0, 1'h0},
                     '{32'h8, 32'h3, 1'h0, 1'h0, 2'h3, 1'h1, 1'h1},
                     '{32'h8, 32'h1B, 1'h1, 1'h1, 2'h3, 1'h0, 1'h1},
                     '{32'h9, 32'h21, 1'h0, 1'h1, 2'h1, 1'h0, 1'h1}};

  leak_alarm_output_config #(.DEBOUNCE_CYCLES(4), .REPLY_UNIT_CYCLES(UNIT)) dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .leak_i(leak), .disc_i(disc), .cancel_key_i(k_can),
    .second_function_key_i(k_sec), .ext_reset_n_i(ext_n), .reply_req_i(req),
    .reply_go_o(go), .relay_o(relay), .alarm_o(alarm), .leak_out_o(lk_o),
    .disc_out_o(dc_o), .backlight_o(blt), .baud_sel_o(baud), .data8_o(d8),
    .stop_two_o(st2), .parity_o(par), .irq_o(irq));

  host_contact_model #(.HOST_BAUD_CODE(2'h1)) host (
    .sys_clk_i(sys_clk_i), .ext_reset_n_o(ext_n), .reply_req_o(req));

  // Free running 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask

  // Classic cycle: hold the request until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int k;
    @(posedge sys_clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (ack !== 1'h1 && k < 20);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (k >= 20) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic del_area(input logic [31:0] idx, input logic [31:0] cmd);
    wb(1'h1, AREA_IDX_OFS, idx, q);
    wb(1'h1, AREA_CMD_OFS, 32'h1, q);
    wb(1'h1, AREA_CMD_OFS, cmd, q);
  endtask

  task automatic set_pol(input logic [1:0] p);
    wb(1'h1, CTRL_OFS, {29'h0, p, 1'h0}, q);
  endtask

  task automatic chord();
    k_can <= 1'h1;
    k_sec <= 1'h1;
    tick(2);
    k_can <= 1'h0;
    k_sec <= 1'h0;
    tick(3);
  endtask

  // Main sequence
  initial begin
    {sys_clk_i, reset_n_i, cyc, stb, we, leak, disc, k_can, k_sec} = 9'h0;
    {adr, sel, wdat} = 44'h0;
    tick(5);
    reset_n_i <= 1'h1;
    wb(1'h0, CTRL_OFS, 32'h0, q);
    chk("ctrl reset", q, CTRL_RST);
    wb(1'h0, SERIAL_OFS, 32'h0, q);
    chk("serial reset", q, SERIAL_RST);
    wb(1'h0, STATUS_OFS, 32'h0, q);
    chk("status reset", q, 32'h80);
    wb(1'h1, 8'h24, 32'hFFFF_FFFF, q);
    wb(1'h0, 8'h24, 32'h0, q);
    chk("unmapped", q, 32'h0);
    foreach (rows[i]) begin
      wb(1'h1, CTRL_OFS, rows[i].ctrl, q);
      wb(1'h1, SERIAL_OFS, rows[i].ser, q);
      leak <= rows[i].lk;
      tick(3);
      chk("relay", relay, rows[i].rly);
      chk("alarm", alarm, rows[i].lk);
      chk("baud", baud, rows[i].bd);
      chk("stop two", st2, rows[i].st2);
      chk("data8", d8, rows[i].d8);
      chk("parity", par, rows[i].ser[5:4]);
    end
    // Area list: append two, cancel, delete inner, delete sole
    wb(1'h1, AREA_IDX_OFS, 32'h1, q);
    wb(1'h1, AREA_DIST_OFS, 32'h12C, q);
    wb(1'h1, AREA_IDX_OFS, 32'h2, q);
    wb(1'h1, AREA_DIST_OFS, 32'h190, q);
    wb(1'h1, AREA_NAME_OFS, 32'h3333_3333, q);
    del_area(32'h1, 32'h4);
    wb(1'h0, STATUS_OFS, 32'h0, q);
    chk("count after cancel", q[11:7], 32'h3);
    chk("irq masked", irq, 1'h0);
    wb(1'h1, IRQ_MASK_OFS, 32'h4, q);
    del_area(32'h1, 32'h2);
    wb(1'h0, STATUS_OFS, 32'h0, q);
    chk("count after delete", q[11:7], 32'h2);
    chk("irq on delete", irq, 1'h1);
    wb(1'h1, AREA_IDX_OFS, 32'h1, q);
    wb(1'h0, AREA_NAME_OFS, 32'h0, q);
    chk("shifted name", q, 32'h3333_3333);
    wb(1'h0, AREA_DIST_OFS, 32'h0, q);
    chk("shifted dist", q, 32'h190);
    wb(1'h1, IRQ_STAT_OFS, 32'h4, q);
    tick(2);
    chk("irq cleared", irq, 1'h0);
    del_area(32'h1, 32'h2);
    wb(1'h1, AREA_NAME_OFS, 32'h1111_1111, q);
    del_area(32'h0, 32'h2);
    wb(1'h0, STATUS_OFS, 32'h0, q);
    chk("sole count", q[11:7], 32'h1);
    wb(1'h0, AREA_NAME_OFS, 32'h0, q);
    chk("default name", q, AREA_DEF_NAME);
    wb(1'h0, AREA_DIST_OFS, 32'h0, q);
    chk("default dist", q, 32'h2BB);
    // Reset policies
    set_pol(POL_AUTO);
    leak <= 1'h1;
    tick(3);
    chord();
    chk("auto ignores reset", alarm, 1'h1);
    leak <= 1'h0;
    tick(3);
    chk("auto self clear", alarm, 1'h0);
    set_pol(POL_MANUAL_ONE);
    leak <= 1'h1;
    tick(3);
    chord();
    chk("manual alarm", alarm, 1'h0);
    chk("manual leak out", lk_o, 1'h1);
    chk("manual backlight", blt, 1'h1);
    leak <= 1'h0;
    tick(3);
    chk("manual self clear", lk_o, 1'h0);
    set_pol(POL_LATCHED);
    leak <= 1'h1;
    disc <= 1'h1;
    tick(3);
    host.set_contact(1'h1);
    tick(12);
    chk("contact reset", alarm, 1'h0);
    chk("contact keeps disc", dc_o, 1'h1);
    host.set_contact(1'h0);
    tick(12);
    leak <= 1'h0;
    disc <= 1'h0;
    tick(3);
    chk("latched leak", lk_o, 1'h1);
    chk("latched disc", dc_o, 1'h1);
    chord();
    chk("latched cleared", lk_o, 1'h0);
    chk("backlight cleared", blt, 1'h0);
    // Reply delay of zero and two units, then clamp
    for (int d = 0; d < 3; d += 2) begin
      wb(1'h1, SERIAL_OFS, 32'h0000_0105 | (d << 16), q);
      host.send_request();
      n = 0;
      do begin
        @(posedge sys_clk_i);
        n++;
      end while (go !== 1'h1 && n < 50);
      chk("reply wait", n, d * UNIT + 2);
      tick(1);
      chk("reply pulse", go, 1'h0);
    end
    wb(1'h1, SERIAL_OFS, 32'h007F_0105, q);
    wb(1'h0, SERIAL_OFS, 32'h0, q);
    chk("delay clamp", q, 32'h0063_0105);
    // Second reset in mid-run
    wb(1'h1, CTRL_OFS, 32'h9, q);
    reset_n_i <= 1'h0;
    tick(2);
    reset_n_i <= 1'h1;
    wb(1'h0, CTRL_OFS, 32'h0, q);
    chk("ctrl after reset", q, CTRL_RST);
    chk("relay after reset", relay, 1'h0);
    summarize();
  end
endmodule
